/* logic/bcag_defs.svh */
// bcag_defs.svh: offsets, thresholds, reset values, timing counts
// assumes a 50 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef BCAG_DEFS_SVH
`define BCAG_DEFS_SVH
`define BCAG_CLK_NS 20
`define BCAG_SEC_NS 1000000000
`define BCAG_OFF_CTRL 32'h0000_0000
`define BCAG_OFF_FILT 32'h0000_0004
`define BCAG_OFF_OFFS 32'h0000_0008
`define BCAG_OFF_LMD 32'h0000_000C
`define BCAG_OFF_NAC 32'h0000_0010
`define BCAG_OFF_DCR 32'h0000_0014
`define BCAG_OFF_STAT 32'h0000_0018
`define BCAG_RST_CTRL 4'h5
`define BCAG_RST_FILT 8'h96
`define BCAG_RST_LMD 16'h8400
`define BCAG_DTHR_NUM 32'h0000_AFC8
`define BCAG_CTHR_NUM 32'h0000_DBBA
`define BCAG_FDQ_UV 32'hFFFF_F060
`define BCAG_FAST_UV 32'hFFFD_B610
`define BCAG_TEMP_HOT 8'h28
`define BCAG_QUANT 32'h0001_86A0
`define BCAG_SD_THR64 32'h0151_8000
`define BCAG_SD_THR47 32'h00F7_DA00
`define BCAG_CI_LIMIT 8'h40
`define BCAG_CPI_MAX 8'hFF
`endif

/* logic/bcag_pkg.sv */
// bcag_pkg: the state record of the charge accounting core
// constants live in bcag_defs.svh; this file holds types only
package bcag_pkg;
  typedef struct packed {
    logic awr;
    logic wr;
    logic bv;
    logic arr;
    logic rv;
    logic [31:0] rdata;
    logic [3:0] ctrl;
    logic [7:0] filt;
    logic [15:0] offs;
    logic [15:0] learned_capacity;
    logic [15:0] available_charge;
    logic [15:0] discharge_counter;
    logic [7:0] charge_cycle_counter;
    logic [31:0] chg_acc;
    logic [31:0] dis_acc;
    logic [31:0] sd_acc;
    logic [31:0] sec_cnt;
    logic [7:0] rate_cnt;
    logic fast;
    logic rate_known;
    logic charging;
    logic last_up;
    logic valid_discharge_flag;
    logic edv_armed;
    logic done_prev;
    logic disp;
    logic cco;
  } bcag_state_t;
endpackage : bcag_pkg

/* logic/bcag_core.sv */
// bcag_core: charge accounting of a battery gas gauge with AXI4-Lite registers
// assumes signed sense samples in microvolts, temperature in degrees C,
// all inputs synchronous to aclk
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "bcag_defs.svh"

module bcag_core #(
  parameter int unsigned SEC_CYCLES = `BCAG_SEC_NS / `BCAG_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [19:0] sense_sample,
  input wire logic sample_valid,
  input wire logic signed [7:0] temp_c,
  input wire logic charge_done,
  input wire logic first_empty_flag,
  output logic charge_control_out,
  output logic display_on
);

  bcag_pkg::bcag_state_t q, d;

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // self-discharge range index 0..7 from temperature, nominal at index 2
  function automatic logic [2:0] sd_range(input logic signed [7:0] t);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++) begin
      // compare as signed integers so temperatures below zero stay in range 0
      if (int'(t) >= i * 10) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : sd_range

  // number of 10 C steps below 10 C, capped at 7
  function automatic logic [2:0] cold_steps(input logic signed [7:0] t);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < 8; i++) begin
      // signed compare; an unsigned one would lose every step below zero
      if (int'(t) < 10 - 10 * (i - 1)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : cold_steps

  logic signed [31:0] vc, dthr, cthr;
  logic [7:0] filt_nz;
  logic [31:0] vmag, eff, dfac, sd_thr;
  logic sec_tick, do_chg, do_dis, do_sd, valid_chg, wr_go, rd_go;

  // thresholds from the filter setting; zero treated as one to avoid a divide by zero
  assign filt_nz = (q.filt == 8'h00) ? 8'h01 : q.filt;
  assign dthr = -($signed(`BCAG_DTHR_NUM) / $signed({24'h0, filt_nz}));
  assign cthr = $signed(`BCAG_CTHR_NUM) / $signed({24'h0, filt_nz});
  assign vc = 32'(sense_sample) + 32'($signed(q.offs));
  assign vmag = vc[31] ? 32'(-vc) : 32'(vc);
  assign sec_tick = (q.sec_cnt == 32'(SEC_CYCLES - 1));

  // efficiency in percent; fast value until the rate is known
  always_comb begin
    if (q.fast || !q.rate_known) begin
      eff = (temp_c > $signed(`BCAG_TEMP_HOT)) ? 32'd90 : 32'd95;
    end else begin
      eff = (temp_c > $signed(`BCAG_TEMP_HOT)) ? 32'd75 : 32'd80;
    end
  end

  // discharge factor in percent
  always_comb begin
    if (vc < $signed(`BCAG_FAST_UV)) begin
      dfac = 32'd105;
    end else begin
      dfac = 32'd100 + 32'd5 * 32'(cold_steps(temp_c));
    end
  end

  // self-discharge threshold per selection; ticks weigh nac by the range shift
  assign sd_thr = (q.ctrl[1:0] == 2'h1) ? `BCAG_SD_THR64 : `BCAG_SD_THR47;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.awr && !q.bv;
  assign rd_go = s_axi_arvalid && !q.arr && !q.rv;

  // next state of the whole core
  always_comb begin
    d = q;
    do_chg = 1'b0;
    do_dis = 1'b0;
    do_sd = 1'b0;
    valid_chg = 1'b0;
    d.awr = 1'b0;
    d.wr = 1'b0;
    d.arr = 1'b0;
    d.sec_cnt = sec_tick ? 32'h0000_0000 : q.sec_cnt + 32'h0000_0001;
    if (first_empty_flag) begin
      d.edv_armed = 1'b1;
    end

    // sample classification and compensated accumulation
    if (sample_valid) begin
      if (vc > cthr) begin
        d.charging = 1'b1;
      end else if (vc < cthr) begin
        d.charging = 1'b0;
      end
      if (d.charging) begin
        d.chg_acc = q.chg_acc + vmag * eff;
      end else if (vc < dthr) begin
        d.dis_acc = q.dis_acc + vmag * dfac;
      end
      // samples inside the filter band add nothing
      if (q.ctrl[3:2] == 2'h1) begin
        d.disp = d.charging || (vc < $signed(`BCAG_FDQ_UV));
      end
    end
    if (q.ctrl[3:2] == 2'h0) begin
      d.disp = 1'b0;
    end else if (q.ctrl[3]) begin
      d.disp = 1'b1;
    end

    // one count per cycle at most; the accumulator keeps the excess
    if (d.chg_acc >= `BCAG_QUANT) begin
      d.chg_acc = d.chg_acc - `BCAG_QUANT;
      do_chg = 1'b1;
    end
    if (d.dis_acc >= `BCAG_QUANT) begin
      d.dis_acc = d.dis_acc - `BCAG_QUANT;
      do_dis = 1'b1;
    end

    // self-discharge, temperature compensated only
    if (sec_tick && q.ctrl[1:0] != 2'h0 && q.ctrl[1:0] != 2'h3) begin
      d.sd_acc = q.sd_acc + (32'(q.available_charge) << sd_range(temp_c));
    end
    if (d.sd_acc >= sd_thr) begin
      d.sd_acc = d.sd_acc - sd_thr;
      do_sd = 1'b1;
    end

    // charge count into the two-byte counter
    if (do_chg && q.available_charge < q.learned_capacity) begin
      d.available_charge = q.available_charge;
      if (!q.last_up) begin
        d.available_charge[7:0] = 8'h00;
      end
      valid_chg = (d.available_charge[7:0] == 8'hFF);
      d.available_charge = d.available_charge + 16'h0001;
      d.last_up = 1'b1;
      d.rate_cnt = (q.rate_cnt == 8'hFF) ? q.rate_cnt : q.rate_cnt + 8'h01;
    end else if (do_dis) begin
      if (q.available_charge != 16'h0000) begin
        d.available_charge = q.available_charge - 16'h0001;
      end
      if (!first_empty_flag && q.discharge_counter != 16'hFFFF) begin
        d.discharge_counter = q.discharge_counter + 16'h0001;
      end
      d.last_up = 1'b0;
    end else if (do_sd && q.available_charge != 16'h0000) begin
      d.available_charge = q.available_charge - 16'h0001;
      if (q.discharge_counter != 16'hFFFF) begin
        d.discharge_counter = q.discharge_counter + 16'h0001;
      end
      d.last_up = 1'b0;
    end

    // valid charge side effects
    if (valid_chg) begin
      if (q.charge_cycle_counter != `BCAG_CPI_MAX) begin
        d.charge_cycle_counter = q.charge_cycle_counter + 8'h01;
      end
      if (q.edv_armed) begin
        d.available_charge = 16'h0000;
        d.edv_armed = first_empty_flag; // a new empty event in the same cycle wins
        if (q.valid_discharge_flag) begin
          d.learned_capacity = q.discharge_counter;
          d.charge_cycle_counter = 8'h00;
        end
      end
      d.valid_discharge_flag = 1'b0;
    end

    // charge rate measurement over each second
    if (!d.charging) begin
      d.rate_known = 1'b0;
      d.rate_cnt = 8'h00;
    end else if (sec_tick) begin
      d.fast = (d.rate_cnt >= 8'h02);
      d.rate_known = 1'b1;
      d.rate_cnt = 8'h00;
    end

    // charge-complete on the rising edge only, so a held level acts once
    d.done_prev = charge_done;
    if (charge_done && !q.done_prev) begin
      if (q.ctrl[1:0] == 2'h1) begin
        d.available_charge = q.learned_capacity;
      end else if (q.ctrl[1:0] == 2'h2 && 32'(q.available_charge) * 32'd100 < 32'(q.learned_capacity) * 32'd94) begin
        d.available_charge = 16'(32'(q.learned_capacity) * 32'd94 / 32'd100);
      end
      d.valid_discharge_flag = 1'b1;
    end

    if (d.available_charge == d.learned_capacity) begin
      d.discharge_counter = 16'h0000;
    end

    // register writes after datapath updates, so software wins the cycle
    if (wr_go) begin
      d.awr = 1'b1;
      d.wr = 1'b1;
      d.bv = 1'b1;
      case (32'(s_axi_awaddr[7:0]))
        `BCAG_OFF_CTRL: d.ctrl = 4'(merge(32'(q.ctrl), s_axi_wdata, s_axi_wstrb));
        `BCAG_OFF_FILT: d.filt = 8'(merge(32'(q.filt), s_axi_wdata, s_axi_wstrb));
        `BCAG_OFF_OFFS: d.offs = 16'(merge(32'(q.offs), s_axi_wdata, s_axi_wstrb));
        `BCAG_OFF_LMD: d.learned_capacity = 16'(merge(32'(q.learned_capacity), s_axi_wdata, s_axi_wstrb));
        default: d.bv = 1'b1;
      endcase
    end else if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end

    // read mux; unmapped offsets read zero with OKAY
    if (rd_go) begin
      d.arr = 1'b1;
      d.rv = 1'b1;
      case (32'(s_axi_araddr[7:0]))
        `BCAG_OFF_CTRL: d.rdata = 32'(q.ctrl);
        `BCAG_OFF_FILT: d.rdata = 32'(q.filt);
        `BCAG_OFF_OFFS: d.rdata = 32'(q.offs);
        `BCAG_OFF_LMD: d.rdata = 32'(q.learned_capacity);
        `BCAG_OFF_NAC: d.rdata = 32'(q.available_charge);
        `BCAG_OFF_DCR: d.rdata = 32'(q.discharge_counter);
        `BCAG_OFF_STAT: d.rdata = {16'h0000, q.charge_cycle_counter, 3'h0, q.cco,
                                   q.fast, (q.charge_cycle_counter >= `BCAG_CI_LIMIT), q.valid_discharge_flag, q.charging};
        default: d.rdata = 32'h0000_0000;
      endcase
    end else if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end

    d.cco = (32'(d.available_charge) * 32'd100 > 32'(d.learned_capacity) * 32'd94) || d.charging;
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= `BCAG_RST_CTRL;
      q.filt <= `BCAG_RST_FILT;
      q.learned_capacity <= `BCAG_RST_LMD;
      q.available_charge <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awr;
  assign s_axi_wready = q.wr;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = 2'h0;
  assign charge_control_out = q.cco;
  assign display_on = q.disp;

endmodule : bcag_core

/* testbench/bcag_core_props.sv */
// bcag_core_props: bus handshake and charge-control checks on the core pins
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
module bcag_core_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [19:0] sense_sample,
  input wire logic sample_valid,
  input wire logic charge_control_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset must not mask its own check
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !charge_control_out && !s_axi_bvalid && !s_axi_rvalid) else $error("active after reset");
  // write and read answers come one cycle after the take edge
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
    !s_axi_awready |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write lost");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=>
    s_axi_arready && s_axi_rvalid) else $error("read lost");
  a_b_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid) && $past(s_axi_wvalid)) else $error("response without write");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response kept");
  a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data kept");
  a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("long ready");
  a_wr_pair: assert property (s_axi_awready == s_axi_wready) else $error("ready split");
  // far above any charge threshold, whatever offset or filter is set
  a_charge_cco: assert property (sample_valid && sense_sample > 20'sh1D4C0 |->
    ##[1:3] charge_control_out) else $error("charge control missing");
endmodule : bcag_core_props
bind bcag_core bcag_core_props i_props (.*);

/* testbench/bcag_front_model.sv */
// bcag_front_model: sense front end and external charge controller
// assumes go is a one-cycle pulse and lvl, n, gap hold while busy
`timescale 1ns/1ps
module bcag_front_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic signed [19:0] lvl,
  input wire logic [7:0] n,
  input wire logic [7:0] gap,
  input wire logic fin,
  output logic busy,
  output logic signed [19:0] sense_sample = 20'sh00000,
  output logic sample_valid = 1'b0,
  output logic charge_done = 1'b0
);
  logic [7:0] left = 8'h00;
  logic [7:0] tick = 8'h00;
  assign busy = left != 8'h00;
  // n samples, gap cycles apart; bus toggles between so stale data never passes
  always @(posedge aclk) begin
    sample_valid <= 1'b0;
    sense_sample <= ~sense_sample;
    charge_done <= fin; // controller reports done as a level
    if (go) begin
      left <= n;
      tick <= 8'h00;
    end else if (busy && tick == 8'h00) begin
      sample_valid <= 1'b1;
      sense_sample <= lvl;
      left <= left - 8'h01;
      tick <= gap - 8'h01;
    end else if (busy) begin
      tick <= tick - 8'h01;
    end
  end
endmodule : bcag_front_model

/* testbench/tb_top.sv */
// tb_top: self-checking bench of bcag_core with a front-end model
// assumes bcag_defs.svh on the include path; one second is 100 cycles
`timescale 1ns/1ps
`include "bcag_defs.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, first_empty_flag = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic charge_control_out, display_on, sample_valid, charge_done, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic signed [19:0] sense_sample, lvl = 20'sh0;
  logic signed [7:0] temp_c = 8'sh19;
  logic go = 1'b0, fin = 1'b0;
  logic [7:0] n = 8'h0, gap = 8'h0, lf = 8'h30;
  logic [31:0] ra[6] = '{32'h0, 32'h4, 32'hC, 32'h10, 32'h14, 32'h20};
  logic [31:0] re[6] = '{32'h5, 32'h96, 32'h8400, 32'h0, 32'h0, 32'h0};
  int errors = 0, num_checks = 0, available_charge = 0, discharge_counter = 0, dn = 0;
  // sense level, temperature, samples, spacing of each traffic row
  int rv[7] = '{200000, 2000, -2000, -2000, 2000, -200000, -200};
  int rt[7] = '{25, 45, 25, 5, 25, 25, 25};
  int rn[7] = '{2, 100, 20, 20, 1, 1, 5};
  int rg[7] = '{200, 4, 4, 4, 4, 220, 4};
  bcag_core #(.SEC_CYCLES(100)) i_dut (.*);
  bcag_front_model i_front (.*);
  initial forever #10 aclk = ~aclk;
  // factor in percent; zero inside the default filter band
  function automatic int fac(int v, int t);
    if (v > 56250 / 150) return t > 40 ? 90 : 95;
    if (v >= -45000 / 150) return 0;
    if (v < -150000) return 105;
    return 100 + (t < 10 ? 5 * ((19 - t) / 10) : 0);
  endfunction : fac
  function automatic logic [7:0] step(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : step
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // write: address and data offered together, each dropped once taken
  task automatic axw(logic [31:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic pulse_done();
    @(posedge aclk);
    fin <= 1'b1;
    repeat (3) @(posedge aclk);
    fin <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_done
  // one traffic row, then the counters against the running model
  task automatic run(int i);
    int d;
    @(posedge aclk);
    temp_c <= 8'(rt[i]);
    lvl <= 20'(rv[i]);
    n <= 8'(rn[i]);
    gap <= 8'(rg[i]);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
    repeat (rg[i]) @(posedge aclk); // backlog drains one count per cycle
    d = rn[i] * (rv[i] < 0 ? -rv[i] : rv[i]) * fac(rv[i], rt[i]) / 100000;
    if (rv[i] > 375) available_charge = (dn != 0 ? available_charge & 32'hFF00 : available_charge) + d;
    if (rv[i] > 375) dn = 0;
    if (d > 0 && rv[i] < 0) available_charge = available_charge > d ? available_charge - d : 0;
    if (d > 0 && rv[i] < 0) discharge_counter += d;
    if (d > 0 && rv[i] < 0) dn = 1;
    axr(32'h10);
    chk(rd, available_charge);
    axr(32'h14);
    chk(rd, discharge_counter);
    axr(32'h18);
    chk(32'(rd[0]), 32'(rv[i] > 375));
    if (i == 1) chk(32'(rd[3]), 32'h1);
    chk(32'(display_on), 32'(rv[i] > 375 || rv[i] < -4000));
  endtask : run
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    lf = step(lf);
    ra[5] = 32'h20 + {lf[5:2], 2'b00};
    for (int i = 0; i < 6; i++) begin
      axr(ra[i]);
      chk(rd, re[i]);
    end
    // read-only counter ignores a write
    axw(32'h10, 32'h1234);
    axr(32'h10);
    chk(rd, 32'h0);
    lf = step(lf);
    rn[1] = 100 + 10 * (lf % 4);
    for (int i = 0; i < 7; i++) run(i);
    // charge complete under 1/47, then 1/64
    axw(32'h0, 32'h6);
    pulse_done();
    axr(32'h10);
    chk(rd, 32'h8400 * 94 / 100);
    chk(32'(charge_control_out), 32'h0);
    axr(32'h18);
    chk(32'(rd[1]), 32'h1);
    axw(32'h0, 32'h5);
    pulse_done();
    axr(32'h10);
    chk(rd, 32'h8400);
    axr(32'h14);
    chk(rd, 32'h0);
    chk(32'(charge_control_out), 32'h1);
    // two carries into the upper byte so far: rows 0 and 1
    axr(32'h18);
    chk(32'(rd[15:8]), 32'h2);
    chk(32'(rd[2]), 32'h0);
    give_verdict();
  end
  // hang guard well past the roughly 1500 cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict();
  end
endmodule : tb_top
